// File: inc/hpl_pkg.sv
// Purpose: constants for the high port data latches (ports five to seven)
// Assumes: special function register access on the core clock
// Notes: addresses of the latch and drive select registers are local picks
//
// Function
// R1: a written latch zero drives the pin low, a written one high when push-pull is selected
// R2: latch one with drive select zero leaves the pin undriven
// R3: a port read returns the sampled pin levels, not the latch
// R4: non-multiplexed memory mode drives port five with address 15:8
// R5: multiplexed memory mode drives port six with address 15:8
// R6: non-multiplexed memory mode drives port six with address 7:0
// R7: multiplexed memory mode uses port seven as shared address/data; the code drives only emifDataOut on port seven and puts address 7:0 on no port
// R8: non-multiplexed memory mode uses port seven as the data bus
// R9: external moves override latches; reads release the data bus drivers
// R10: drive selects reset to open-drain; a one selects push-pull
// R11: read-modify-write reads return the latch contents
package hpl_pkg;

	// ******************************
	// register addresses
	// ******************************
	localparam logic [7:0] ADDR_PORT_FIVE = 8'hD8;
	localparam logic [7:0] ADDR_PORT_SIX = 8'hE8;
	localparam logic [7:0] ADDR_PORT_SEVEN = 8'hF8;
	localparam logic [7:0] ADDR_FIVE_SEL = 8'h9C;
	localparam logic [7:0] ADDR_SIX_SEL = 8'h9D;
	localparam logic [7:0] ADDR_SEVEN_SEL = 8'h9E;

	// ******************************
	// reset values and fields
	// ******************************
	localparam int PORT_WIDTH = 8;
	localparam logic [7:0] LATCH_RESET = 8'hFF;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	localparam int ADDR_HI_MSB = 15;
	localparam int ADDR_HI_LSB = 8;
	localparam int ADDR_LO_MSB = 7;
	localparam int ADDR_LO_LSB = 0;

endpackage

// File: hw/hpl_pin_drive.sv
// Purpose: registered drive of one byte-wide port
// Assumes: override inputs come from the memory interface
// Notes: float has priority over override and latch
`timescale 1ns/100ps
module hpl_pin_drive
	import hpl_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] pushPull,
	input wire logic ovEn,
	input wire logic [WIDTH-1:0] ovValue,
	input wire logic ovFloat,
	// pins
	output logic [WIDTH-1:0] pinOut,
	output logic [WIDTH-1:0] pinOe
);

	typedef struct packed {
		logic [WIDTH-1:0] out;
		logic [WIDTH-1:0] oe;
	} hpl_drive_t;

	hpl_drive_t state;
	hpl_drive_t next_state;
	logic [WIDTH-1:0] value;

	// ******************************
	// drive logic
	// ******************************
	always_comb begin
		value = ovEn ? ovValue : latch; // [R9]
		next_state.out = value; // [R1]
		for (int i = 0; i < WIDTH; i++) begin
			next_state.oe[i] = !value[i] || pushPull[i]; // [R2] [R10]
		end
		if (ovFloat) begin
			next_state.oe = '0; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state.out <= '1;
			state.oe <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pinOut = state.out;
	assign pinOe = state.oe;

endmodule

// File: hw/hpl_port_top.sv
// Purpose: data latches and drive selects of ports five, six and seven
// Assumes: pins sampled synchronously; one register access per cycle
// Notes: read data and memory interface drive appear one cycle after their cause, latch writes reach the pins two cycles later
`timescale 1ns/100ps
module hpl_port_top
	import hpl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// special function register access
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRead,
	input wire logic sfrRmw,
	output logic [7:0] sfrRdData,
	// external memory interface
	input wire logic emifActive,
	input wire logic emifMuxed,
	input wire logic [15:0] emifAddr,
	input wire logic [7:0] emifDataOut,
	input wire logic emifDataOe,
	input wire logic emifRead,
	// port five pins
	input wire logic [7:0] pin5In,
	output logic [7:0] pin5Out,
	output logic [7:0] pin5Oe,
	// port six pins
	input wire logic [7:0] pin6In,
	output logic [7:0] pin6Out,
	output logic [7:0] pin6Oe,
	// port seven pins
	input wire logic [7:0] pin7In,
	output logic [7:0] pin7Out,
	output logic [7:0] pin7Oe
);

	typedef struct packed {
		logic [7:0] latch5;
		logic [7:0] latch6;
		logic [7:0] latch7;
		logic [7:0] sel5;
		logic [7:0] sel6;
		logic [7:0] sel7;
		logic [7:0] rdData;
	} hpl_regs_t;

	hpl_regs_t state;
	hpl_regs_t next_state;
	logic ov5En;
	logic ov6En;
	logic ov7En;
	logic ov7Float;
	logic [7:0] ov6Value;
	logic [7:0] addrHi;
	logic [7:0] addrLo;

	// ******************************
	// register file
	// ******************************
	always_comb begin
		next_state = state;
		if (sfrWrite) begin
			case (sfrAddr)
				ADDR_PORT_FIVE: next_state.latch5 = sfrWrData; // [R1]
				ADDR_PORT_SIX: next_state.latch6 = sfrWrData;
				ADDR_PORT_SEVEN: next_state.latch7 = sfrWrData;
				ADDR_FIVE_SEL: next_state.sel5 = sfrWrData; // [R10]
				ADDR_SIX_SEL: next_state.sel6 = sfrWrData;
				ADDR_SEVEN_SEL: next_state.sel7 = sfrWrData;
				default: next_state.sel5 = state.sel5;
			endcase
		end
		if (sfrRead) begin
			case (sfrAddr)
				ADDR_PORT_FIVE:
					next_state.rdData = sfrRmw ? state.latch5 : pin5In; // [R3] [R11]
				ADDR_PORT_SIX:
					next_state.rdData = sfrRmw ? state.latch6 : pin6In; // [R3] [R11]
				ADDR_PORT_SEVEN:
					next_state.rdData = sfrRmw ? state.latch7 : pin7In; // [R3] [R11]
				ADDR_FIVE_SEL: next_state.rdData = state.sel5;
				ADDR_SIX_SEL: next_state.rdData = state.sel6;
				ADDR_SEVEN_SEL: next_state.rdData = state.sel7;
				default: next_state.rdData = READ_NONE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state.latch5 <= LATCH_RESET;
			state.latch6 <= LATCH_RESET;
			state.latch7 <= LATCH_RESET;
			state.sel5 <= SEL_RESET; // [R10]
			state.sel6 <= SEL_RESET;
			state.sel7 <= SEL_RESET;
			state.rdData <= READ_NONE;
		end else begin
			state <= next_state;
		end
	end

	assign sfrRdData = state.rdData;

	// ******************************
	// memory interface takeover
	// ******************************
	assign addrHi = emifAddr[ADDR_HI_MSB:ADDR_HI_LSB];
	assign addrLo = emifAddr[ADDR_LO_MSB:ADDR_LO_LSB];
	assign ov5En = emifActive && !emifMuxed; // [R4]
	assign ov6En = emifActive; // [R5] [R6]
	assign ov6Value = emifMuxed ? addrHi : addrLo; // [R5] [R6]
	assign ov7En = emifActive && emifDataOe; // [R7] [R8]
	assign ov7Float = emifActive && emifRead; // [R9]

	// ******************************
	// pin drivers
	// ******************************
	hpl_pin_drive #(.WIDTH(PORT_WIDTH)) drive5 (
		.clk(clk),
		.reset(reset),
		.latch(state.latch5),
		.pushPull(state.sel5),
		.ovEn(ov5En),
		.ovValue(addrHi),
		.ovFloat(1'b0),
		.pinOut(pin5Out),
		.pinOe(pin5Oe)
	);

	hpl_pin_drive #(.WIDTH(PORT_WIDTH)) drive6 (
		.clk(clk),
		.reset(reset),
		.latch(state.latch6),
		.pushPull(state.sel6),
		.ovEn(ov6En),
		.ovValue(ov6Value),
		.ovFloat(1'b0),
		.pinOut(pin6Out),
		.pinOe(pin6Oe)
	);

	hpl_pin_drive #(.WIDTH(PORT_WIDTH)) drive7 (
		.clk(clk),
		.reset(reset),
		.latch(state.latch7),
		.pushPull(state.sel7),
		.ovEn(ov7En),
		.ovValue(emifDataOut),
		.ovFloat(ov7Float),
		.pinOut(pin7Out),
		.pinOe(pin7Oe)
	);

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence writeSixLow;
		sfrWrite && sfrAddr == ADDR_PORT_SIX && !sfrWrData[0];
	endsequence

	sequence writeSixHigh;
		sfrWrite && sfrAddr == ADDR_PORT_SIX && sfrWrData[1];
	endsequence

	sequence quietBus;
		!emifActive;
	endsequence

	chk_write_low_drive: assert property ( // [R1]
		writeSixLow ##1 quietBus |=> pin6Oe[0] && !pin6Out[0])
		else $error("written zero did not drive pin low");

	chk_push_pull_high: assert property ( // [R1]
		state.latch6[0] && state.sel6[0] && !emifActive
		|=> pin6Oe[0] && pin6Out[0])
		else $error("push-pull one not driven high");

	chk_open_drain_float: assert property ( // [R2]
		state.latch5[1] && !state.sel5[1] && !ov5En |=> !pin5Oe[1])
		else $error("open-drain one was driven");

	chk_pin_read_value: assert property ( // [R3]
		sfrRead && sfrAddr == ADDR_PORT_SEVEN && !sfrRmw
		|=> sfrRdData == $past(pin7In))
		else $error("port read did not return pin levels");

	chk_rmw_latch_read: assert property ( // [R11]
		sfrRead && sfrAddr == ADDR_PORT_FIVE && sfrRmw
		|=> sfrRdData == $past(state.latch5))
		else $error("rmw read did not return latch");

	chk_five_addr_high: assert property ( // [R4]
		emifActive && !emifMuxed |=> pin5Out == $past(addrHi))
		else $error("port five lacks upper address");

	chk_six_mux_high: assert property ( // [R5]
		emifActive && emifMuxed |=> pin6Out == $past(addrHi))
		else $error("port six lacks upper address in muxed mode");

	chk_six_addr_low: assert property ( // [R6]
		emifActive && !emifMuxed |=> pin6Out == $past(addrLo))
		else $error("port six lacks lower address");

	chk_seven_data_out: assert property ( // [R7] [R8]
		emifActive && emifDataOe && !emifRead
		|=> pin7Out == $past(emifDataOut))
		else $error("port seven lacks interface byte");

	chk_read_release_bus: assert property ( // [R9]
		emifActive && emifRead |=> pin7Oe == 8'h00)
		else $error("data bus driven during read");

	chk_reset_open_drain: assert property ( // [R10]
		@(posedge clk) disable iff (1'b0)
		reset |=> state.sel5 == SEL_RESET && state.sel7 == SEL_RESET
		##1 reset || pin7Oe == 8'h00 || state.latch7 != LATCH_RESET)
		else $error("drive select not open-drain after reset");

	chk_write_high_drive: assert property ( // [R1]
		writeSixHigh ##1 !emifActive && state.sel6[1]
		|=> pin6Oe[1] && pin6Out[1])
		else $error("written one did not drive pin high");

	chk_select_read_back: assert property ( // [R10]
		sfrRead && sfrAddr == ADDR_SIX_SEL |=> sfrRdData == $past(state.sel6))
		else $error("drive select read back wrong");

	chk_muxed_five_latch: assert property ( // [R4]
		emifActive && emifMuxed |=> pin5Out == $past(state.latch5))
		else $error("port five left its latch in muxed mode");

endmodule

// File: testbench/hpl_pin_model.sv
// Purpose: pin level model for ports five to seven
// Assumes: weak pull-up on every pin
// Notes: an undriven pin takes the far device's value where it drives
`timescale 1ns/100ps
module hpl_pin_model (
	// device side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	// far side
	input wire logic [7:0] extValue,
	input wire logic [7:0] extEn,
	output logic [7:0] pinLevel
);
	// undriven open-drain ones rise to the pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pinOe[i]) begin
				pinLevel[i] = pinOut[i];
			end else begin
				pinLevel[i] = extEn[i] ? extValue[i] : 1'b1;
			end
		end
	end
endmodule

// File: testbench/tb_high_port_data_latches.sv
// Purpose: self-checking bench for the high port data latches
// Assumes: one write or read per task, pins through the pin model
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module tb_high_port_data_latches;
	import hpl_pkg::*;
	// ************
	// stimulus
	// ************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWrite = 1'b0;
	logic sfrRead = 1'b0;
	logic sfrRmw = 1'b0;
	logic emifActive = 1'b0;
	logic emifMuxed = 1'b0;
	logic emifDataOe = 1'b0;
	logic emifRead = 1'b0;
	logic [15:0] emifAddr = 16'h0000;
	logic [7:0] emifDataOut = 8'h00;
	logic [7:0] extV = 8'h00;
	logic [7:0] extE = 8'h00;
	logic [7:0] sfrRdData, po5, oe5, po6, oe6, po7, oe7, p5, p6, p7;
	int bad_count = 0;
	int check_count = 0;
	always #10 clk = ~clk;
	hpl_port_top uut (.clk(clk), .reset(reset), .sfrAddr(sfrAddr),
		.sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRead(sfrRead),
		.sfrRmw(sfrRmw), .sfrRdData(sfrRdData), .emifActive(emifActive),
		.emifMuxed(emifMuxed), .emifAddr(emifAddr),
		.emifDataOut(emifDataOut), .emifDataOe(emifDataOe),
		.emifRead(emifRead), .pin5In(p5), .pin5Out(po5), .pin5Oe(oe5),
		.pin6In(p6), .pin6Out(po6), .pin6Oe(oe6), .pin7In(p7),
		.pin7Out(po7), .pin7Oe(oe7));
	hpl_pin_model m5 (.pinOut(po5), .pinOe(oe5), .extValue(8'h00),
		.extEn(8'h00), .pinLevel(p5));
	hpl_pin_model m6 (.pinOut(po6), .pinOe(oe6), .extValue(8'h00),
		.extEn(8'h00), .pinLevel(p6));
	hpl_pin_model m7 (.pinOut(po7), .pinOe(oe7), .extValue(extV),
		.extEn(extE), .pinLevel(p7));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [23:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		sfrAddr = a;
		sfrWrData = d;
		sfrWrite = 1'b1;
		step(1);
		sfrWrite = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic rmw,
		output logic [7:0] d);
		sfrAddr = a;
		sfrRmw = rmw;
		sfrRead = 1'b1;
		step(1);
		sfrRead = 1'b0;
		sfrRmw = 1'b0;
		step(1);
		d = sfrRdData;
	endtask
	task automatic t_reset;
		logic [7:0] d;
		chk("oeRst", {oe5, oe6, oe7}, 24'h00_0000);
		chk("outRst", {po5, po6, po7}, 24'hFF_FFFF);
		rd(ADDR_SIX_SEL, 1'b0, d);
		chk("sel6", d, SEL_RESET);
		rd(ADDR_PORT_SEVEN, 1'b1, d);
		chk("latch7", d, 8'hFF);
		rd(ADDR_PORT_FIVE, 1'b1, d);
		chk("latch5", d, LATCH_RESET);
		rd(8'h00, 1'b0, d);
		chk("unmapped", d, READ_NONE);
		$display("test reset done");
	endtask
	task automatic t_drive;
		logic [7:0] d;
		wr(ADDR_SIX_SEL, 8'hFF);
		wr(ADDR_PORT_SIX, 8'h5A);
		chk("out6", po6, 8'h5A);
		chk("oe6", oe6, 8'hFF);
		wr(ADDR_SIX_SEL, 8'h0F);
		chk("oe6od", oe6, 8'hAF);
		rd(ADDR_PORT_SIX, 1'b0, d);
		chk("pins6", d, 8'h5A);
		$display("test drive done");
	endtask
	task automatic t_read;
		logic [7:0] d;
		extV = 8'h3C;
		extE = 8'hFF;
		rd(ADDR_PORT_SEVEN, 1'b0, d);
		chk("pins7", d, 8'h3C);
		rd(ADDR_PORT_SEVEN, 1'b1, d);
		chk("rmw7", d, 8'hFF);
		extE = 8'h00;
		$display("test read done");
	endtask
	task automatic t_external_memory_interface;
		wr(ADDR_FIVE_SEL, 8'hFF);
		wr(ADDR_SIX_SEL, 8'hFF);
		wr(ADDR_SEVEN_SEL, 8'hFF);
		emifActive = 1'b1;
		emifAddr = 16'h1234;
		emifDataOut = 8'hC3;
		emifDataOe = 1'b1;
		step(2);
		chk("nm56", {po5, po6}, 16'h1234);
		chk("nm7", {po7, oe7}, 16'hC3FF);
		chk("oe5", oe5, 8'hFF);
		emifMuxed = 1'b1;
		emifAddr = 16'hABCD;
		emifDataOut = 8'hCD;
		step(2);
		chk("mx56", {po5, po6}, 16'hFFAB);
		chk("mx7", po7, 8'hCD);
		emifRead = 1'b1;
		step(2);
		chk("rdOe7", oe7, 8'h00);
		emifActive = 1'b0;
		emifRead = 1'b0;
		emifDataOe = 1'b0;
		step(2);
		chk("back", {po6, po7}, 16'h5AFF);
		$display("test memory interface done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		conclude;
	end
	initial begin
		step(2);
		reset = 1'b0;
		t_reset;
		t_drive;
		t_read;
		t_external_memory_interface;
		conclude;
	end
endmodule
